/* File: logic/cst_pkg.sv */
/*
 * cst_pkg: register offsets, field positions, reset values and codes for
 * the converter self-test and output configuration register bank.
 * assumes: byte-wide registers at their printed offsets on an 8-bit
 * address supplied by the host serial port controller.
 */
package cst_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_SELF_TEST = 8'h0e;
  localparam logic [7:0] ADDR_ANALOG = 8'h0f;
  localparam logic [7:0] ADDR_OFFSET = 8'h10;
  localparam logic [7:0] ADDR_GAIN = 8'h11;
  localparam logic [7:0] ADDR_OUT_FMT = 8'h14;
  localparam logic [7:0] ADDR_OUT_DRIVE = 8'h15;
  localparam logic [7:0] ADDR_PHASE = 8'h16;
  localparam logic [7:0] ADDR_SIG_LOW = 8'h24;
  localparam logic [7:0] ADDR_SIG_HIGH = 8'h25;

  // ==========================================================
  // writable bit masks, reserved bits read as zero
  localparam logic [7:0] MASK_SELF_TEST = 8'h07;
  localparam logic [7:0] MASK_ANALOG = 8'hf7;
  localparam logic [7:0] MASK_PHASE = 8'h8f;

  // ==========================================================
  // field positions
  localparam int SELF_TEST_CLEAR_BIT = 2;
  localparam int SELF_TEST_MODE_LSB = 0;
  localparam int BW_LSB = 4;
  localparam int DISCONNECT_BIT = 2;
  localparam int COMMON_MODE_BIT = 1;
  localparam int SINGLE_ENDED_BIT = 0;
  localparam int LOGIC_TYPE_LSB = 6;
  localparam int MUX_BIT = 5;
  localparam int OUT_DISABLE_BIT = 4;
  localparam int DDR_BIT = 3;
  localparam int INVERT_BIT = 2;
  localparam int CODING_LSB = 0;
  localparam int TERM_LSB = 4;
  localparam int DRIVE_LSB = 0;
  localparam int PHASE_INV_BIT = 7;
  localparam int PHASE_SEL_LSB = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_SELF_TEST = 8'h00;
  localparam logic [7:0] RST_ANALOG = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'h00;
  localparam logic [7:0] RST_OUT_FMT = 8'h00;
  localparam logic [7:0] RST_OUT_DRIVE = 8'h00;
  localparam logic [7:0] RST_PHASE = 8'h00;

  // ==========================================================
  // codes and timing
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ONE = 2'h1;
  localparam logic [1:0] CODE_OFFSET_BIN = 2'h0;
  localparam logic [1:0] CODE_TWOS = 2'h1;
  localparam logic [1:0] CODE_GRAY = 2'h2;
  localparam logic [1:0] CODE_RSVD = 2'h3;
  localparam int WINDOW_CYCLES = 256;
  localparam logic [15:0] PRBS_SEED = 16'hace1;
  localparam logic [15:0] PRBS_TAPS = 16'hb400;

  typedef enum logic [2:0] {
    CST_IDLE = 3'b001,
    CST_RUN = 3'b010,
    CST_DONE = 3'b100
  } cst_state_t;
endpackage

/* File: logic/cst_config.sv */
/*
 * cst_config: self-test, analog input, trim, output format, output drive
 * and clock phase configuration registers with the digital back end.
 * assumes: host controller gives one-cycle read and write strobes with
 * address and data; encode_tick_in pulses once per converter sample.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - self-test feeds pseudorandom data through path, summing outputs
// - signature readable at the two signature locations
// - clear select high clears signature at start, low keeps it
// - mode field 00 is normal, 01 runs self-test one
// - pseudorandom source drives path; offset, gain, coding alter sum
// - window lasts exactly 256 encode ticks then ends
// - mode field clears at completion unless clear select is low
// - four-bit low-pass bandwidth field, default 0000
// - disconnect bit isolates analog input, conversion continues
// - offset trim is signed twos complement, 0x00 midscale
// - two-bit logic type selects one of four level options
// - mux bit alternates two outputs on one lane
// - output enable bit active low; disabled outputs float
// - dedicated enable pin overrides bit unless pin reassigned
// - double data rate sends word over half the pins twice
// - invert bit inverts the output data bits
// - coding 00 offset binary, 01 twos, 10 gray; default 0x00
// - unsupported coding codes do not take effect
// - drive register: upper termination, lower drive current
// - four-bit phase select picks divider phase, default first
// - phase invert bit inverts the selected phase
// - low location holds signature low byte, high holds high byte
// - signature locations mirror core signature, read only
module cst_config #(
  parameter int W = 16,
  parameter bit HAS_EXT_OE = 1'b1
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic encode_tick_in,
  input wire logic [W-1:0] sample_in,
  input wire logic ext_oe_n_in,
  input wire logic ext_pin_alt_in,
  output logic [W-1:0] data_out,
  output logic data_oe_out,
  output logic lane_sel_out,
  output logic self_test_busy_out,
  output logic analog_disconnect_out,
  output logic [3:0] lpf_bw_out,
  output logic common_mode_en_out,
  output logic single_ended_out,
  output logic [1:0] logic_type_out,
  output logic [3:0] term_sel_out,
  output logic [3:0] drive_sel_out,
  output logic latch_strobe_out,
  output logic serial_clk_out
);
  localparam int WX = W + 10;
  localparam int HW = W / 2;

  // ==========================================================
  // helper functions
  // saturate a wide signed value into W bits
  function automatic logic signed [W-1:0] sat(input logic signed [WX-1:0] v);
    logic signed [WX-1:0] hi;
    logic signed [WX-1:0] lo;
    hi = WX'((1 <<< (W - 1)) - 1);
    lo = -hi - WX'(1);
    if (v > hi)
    begin
      sat = hi[W-1:0];
    end
    else if (v < lo)
    begin
      sat = lo[W-1:0];
    end
    else
    begin
      sat = v[W-1:0];
    end
  endfunction

  function automatic logic [15:0] prbs_step(input logic [15:0] s);
    prbs_step = s[0] ? ((s >> 1) ^ cst_pkg::PRBS_TAPS) : (s >> 1);
  endfunction

  // ==========================================================
  // register file
  logic [7:0] self_test_control, next_self_test_control;
  logic [7:0] analog_input_config, next_analog_input_config;
  logic [7:0] offset_trim, next_offset_trim;
  logic [7:0] gain_trim, next_gain_trim;
  logic [7:0] output_format_control, next_output_format_control;
  logic [7:0] output_drive_settings, next_output_drive_settings;
  logic [7:0] clock_phase_select, next_clock_phase_select;
  logic [1:0] coding_eff, next_coding_eff;
  logic [7:0] next_rd_data;
  logic [15:0] signature_register, next_signature_register;
  cst_pkg::cst_state_t state, next_state;
  logic st_write;
  logic st_start;
  logic clear_sel;

  assign st_write = wr_en_in && (addr_in == cst_pkg::ADDR_SELF_TEST);
  assign st_start = st_write &&
    (wr_data_in[1:0] == cst_pkg::MODE_ONE) && (state == cst_pkg::CST_IDLE);
  assign clear_sel = self_test_control[cst_pkg::SELF_TEST_CLEAR_BIT];

  // next register values, address decode and read mux
  always_comb
  begin
    next_self_test_control = self_test_control;
    next_analog_input_config = analog_input_config;
    next_offset_trim = offset_trim;
    next_gain_trim = gain_trim;
    next_output_format_control = output_format_control;
    next_output_drive_settings = output_drive_settings;
    next_clock_phase_select = clock_phase_select;
    next_coding_eff = coding_eff;
    next_rd_data = 8'h00;
    // completion with clear select high clears the mode field; a host write below wins
    if (state == cst_pkg::CST_DONE && clear_sel)
    begin
      next_self_test_control[1:0] = cst_pkg::MODE_OFF;
    end
    if (wr_en_in)
    begin
      if (addr_in == cst_pkg::ADDR_SELF_TEST)
      begin
        next_self_test_control = wr_data_in & cst_pkg::MASK_SELF_TEST;
      end
      else if (addr_in == cst_pkg::ADDR_ANALOG)
      begin
        next_analog_input_config = wr_data_in & cst_pkg::MASK_ANALOG;
      end
      else if (addr_in == cst_pkg::ADDR_OFFSET)
      begin
        next_offset_trim = wr_data_in;
      end
      else if (addr_in == cst_pkg::ADDR_GAIN)
      begin
        next_gain_trim = wr_data_in;
      end
      else if (addr_in == cst_pkg::ADDR_OUT_FMT)
      begin
        next_output_format_control = wr_data_in;
        if (wr_data_in[1:0] != cst_pkg::CODE_RSVD)
        begin
          next_coding_eff = wr_data_in[1:0];
        end
      end
      else if (addr_in == cst_pkg::ADDR_OUT_DRIVE)
      begin
        next_output_drive_settings = wr_data_in;
      end
      else if (addr_in == cst_pkg::ADDR_PHASE)
      begin
        next_clock_phase_select = wr_data_in & cst_pkg::MASK_PHASE;
      end
    end
    if (rd_en_in)
    begin
      if (addr_in == cst_pkg::ADDR_SELF_TEST)
      begin
        next_rd_data = self_test_control;
      end
      else if (addr_in == cst_pkg::ADDR_ANALOG)
      begin
        next_rd_data = analog_input_config;
      end
      else if (addr_in == cst_pkg::ADDR_OFFSET)
      begin
        next_rd_data = offset_trim;
      end
      else if (addr_in == cst_pkg::ADDR_GAIN)
      begin
        next_rd_data = gain_trim;
      end
      else if (addr_in == cst_pkg::ADDR_OUT_FMT)
      begin
        next_rd_data = output_format_control;
      end
      else if (addr_in == cst_pkg::ADDR_OUT_DRIVE)
      begin
        next_rd_data = output_drive_settings;
      end
      else if (addr_in == cst_pkg::ADDR_PHASE)
      begin
        next_rd_data = clock_phase_select;
      end
      else if (addr_in == cst_pkg::ADDR_SIG_LOW)
      begin
        next_rd_data = signature_register[7:0];
      end
      else if (addr_in == cst_pkg::ADDR_SIG_HIGH)
      begin
        next_rd_data = signature_register[15:8];
      end
    end
  end

  // register file flops
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      self_test_control <= cst_pkg::RST_SELF_TEST;
      analog_input_config <= cst_pkg::RST_ANALOG;
      offset_trim <= cst_pkg::RST_OFFSET;
      gain_trim <= cst_pkg::RST_GAIN;
      output_format_control <= cst_pkg::RST_OUT_FMT;
      output_drive_settings <= cst_pkg::RST_OUT_DRIVE;
      clock_phase_select <= cst_pkg::RST_PHASE;
      coding_eff <= cst_pkg::CODE_OFFSET_BIN;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
    end
    else
    begin
      self_test_control <= next_self_test_control;
      analog_input_config <= next_analog_input_config;
      offset_trim <= next_offset_trim;
      gain_trim <= next_gain_trim;
      output_format_control <= next_output_format_control;
      output_drive_settings <= next_output_drive_settings;
      clock_phase_select <= next_clock_phase_select;
      coding_eff <= next_coding_eff;
      rd_data_out <= next_rd_data;
      rd_valid_out <= rd_en_in;
    end
  end

  // ==========================================================
  // data path: source select, trims, coding, invert
  logic [15:0] prbs, next_prbs;
  logic signed [W-1:0] src;
  logic signed [WX-1:0] wide;
  logic signed [W-1:0] trimmed;
  logic [W-1:0] fmt;
  logic running;

  assign running = (state == cst_pkg::CST_RUN);

  always_comb
  begin
    // pseudorandom stimulus replaces the converter sample during test
    if (running)
    begin
      src = $signed(W'(prbs));
    end
    else if (analog_input_config[cst_pkg::DISCONNECT_BIT])
    begin
      src = '0;
    end
    else
    begin
      src = $signed(sample_in ^ {1'b1, {(W-1){1'b0}}});
    end
    // gain adds a signed fraction of the sample in 1/256 steps
    wide = WX'(src) + WX'($signed(offset_trim)) +
      WX'((WX'(src) * WX'($signed(gain_trim))) >>> 8);
    trimmed = sat(wide);
    case (coding_eff)
      cst_pkg::CODE_TWOS: fmt = trimmed;
      cst_pkg::CODE_GRAY: fmt = (trimmed ^ {1'b1, {(W-1){1'b0}}}) ^
        ((trimmed ^ {1'b1, {(W-1){1'b0}}}) >> 1);
      default: fmt = trimmed ^ {1'b1, {(W-1){1'b0}}};
    endcase
    if (output_format_control[cst_pkg::INVERT_BIT])
    begin
      fmt = ~fmt;
    end
  end

  // ==========================================================
  // self-test sequencer and signature accumulator
  logic [8:0] win_cnt, next_win_cnt;

  always_comb
  begin
    next_state = state;
    next_win_cnt = win_cnt;
    next_prbs = prbs;
    next_signature_register = signature_register;
    case (state)
      cst_pkg::CST_IDLE:
      begin
        if (st_start)
        begin
          next_state = cst_pkg::CST_RUN;
          next_win_cnt = 9'h000;
          next_prbs = cst_pkg::PRBS_SEED;
          if (wr_data_in[cst_pkg::SELF_TEST_CLEAR_BIT])
          begin
            next_signature_register = 16'h0000;
          end
        end
      end
      cst_pkg::CST_RUN:
      begin
        if (encode_tick_in)
        begin
          next_signature_register = signature_register + 16'(fmt);
          next_prbs = prbs_step(prbs);
          next_win_cnt = win_cnt + 9'h001;
          if (win_cnt == 9'(cst_pkg::WINDOW_CYCLES - 1))
          begin
            next_state = cst_pkg::CST_DONE;
          end
        end
      end
      cst_pkg::CST_DONE:
      begin
        next_state = cst_pkg::CST_IDLE;
      end
      default:
      begin
        next_state = cst_pkg::CST_IDLE;
      end
    endcase
  end

  // sequencer flops
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state <= cst_pkg::CST_IDLE;
      win_cnt <= 9'h000;
      prbs <= cst_pkg::PRBS_SEED;
      signature_register <= 16'h0000;
      self_test_busy_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      win_cnt <= next_win_cnt;
      prbs <= next_prbs;
      signature_register <= next_signature_register;
      self_test_busy_out <= (next_state == cst_pkg::CST_RUN);
    end
  end

  // ==========================================================
  // output lanes: enable, double data rate, multiplexing
  logic [W-1:0] next_data;
  logic [HW-1:0] ddr_hold, next_ddr_hold;
  logic next_oe;
  logic next_lane;

  always_comb
  begin
    next_data = data_out;
    next_ddr_hold = ddr_hold;
    next_lane = lane_sel_out;
    // dedicated pin rules unless it has been given another function
    if (HAS_EXT_OE && !ext_pin_alt_in)
    begin
      next_oe = !ext_oe_n_in;
    end
    else
    begin
      next_oe = !output_format_control[cst_pkg::OUT_DISABLE_BIT];
    end
    if (encode_tick_in)
    begin
      if (output_format_control[cst_pkg::DDR_BIT])
      begin
        next_data = {{(W-HW){1'b0}}, fmt[HW-1:0]};
        next_ddr_hold = fmt[W-1:HW];
      end
      else
      begin
        next_data = fmt;
      end
      next_lane = output_format_control[cst_pkg::MUX_BIT] ?
        !lane_sel_out : 1'b0;
    end
    else if (output_format_control[cst_pkg::DDR_BIT])
    begin
      next_data = {{(W-HW){1'b0}}, ddr_hold};
    end
  end

  // output flops
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      data_out <= '0;
      ddr_hold <= '0;
      data_oe_out <= 1'b0;
      lane_sel_out <= 1'b0;
    end
    else
    begin
      data_out <= next_data;
      ddr_hold <= next_ddr_hold;
      data_oe_out <= next_oe;
      lane_sel_out <= next_lane;
    end
  end

  // ==========================================================
  // clock divider phase selection
  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic [3:0] rel_phase;

  always_comb
  begin
    next_div_cnt = div_cnt + 4'h1;
    rel_phase = div_cnt - clock_phase_select[3:0];
  end

  // divider flops; strobe marks the chosen phase
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      div_cnt <= 4'h0;
      latch_strobe_out <= 1'b0;
      serial_clk_out <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      latch_strobe_out <= (rel_phase == 4'h0);
      serial_clk_out <= (rel_phase < 4'h8) ^
        clock_phase_select[cst_pkg::PHASE_INV_BIT];
    end
  end

  // ==========================================================
  // analog and drive controls taken straight from registers
  assign lpf_bw_out = analog_input_config[7:4];
  assign analog_disconnect_out =
    analog_input_config[cst_pkg::DISCONNECT_BIT];
  assign common_mode_en_out = analog_input_config[cst_pkg::COMMON_MODE_BIT];
  assign single_ended_out = analog_input_config[cst_pkg::SINGLE_ENDED_BIT];
  assign logic_type_out = output_format_control[7:6];
  assign term_sel_out = output_drive_settings[7:4];
  assign drive_sel_out = output_drive_settings[3:0];

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence start_clear_s;
    st_start && wr_data_in[cst_pkg::SELF_TEST_CLEAR_BIT];
  endsequence
  sequence start_keep_s;
    st_start && !wr_data_in[cst_pkg::SELF_TEST_CLEAR_BIT];
  endsequence

  sig_clear_a: assert property (start_clear_s |=> signature_register == 0)
    else $error("signature not cleared at start");
  sig_keep_a: assert property (start_keep_s |=> $stable(signature_register))
    else $error("signature lost at start");
  sig_accum_a: assert property (running && encode_tick_in |=>
    signature_register == $past(signature_register) + 16'($past(fmt)))
    else $error("signature did not accumulate");
  window_end_a: assert property (running && encode_tick_in &&
    win_cnt == 9'd255 |=> state == cst_pkg::CST_DONE)
    else $error("window did not end after 256 ticks");
  window_max_a: assert property (running |-> win_cnt < 9'd256)
    else $error("window overran");
  mode_clear_a: assert property (state == cst_pkg::CST_DONE && clear_sel &&
    !st_write |=> self_test_control[1:0] == 2'b00 ##1 !running)
    else $error("mode field not cleared");
  mode_keep_a: assert property (state == cst_pkg::CST_DONE && !clear_sel &&
    !st_write |=> self_test_control[1:0] == $past(self_test_control[1:0]))
    else $error("mode field cleared with clear select low");
  sig_read_a: assert property (rd_en_in && addr_in == 8'h25 && !running
    |=> rd_valid_out && rd_data_out == signature_register[15:8])
    else $error("signature high byte misread");
  sig_ro_a: assert property (wr_en_in && addr_in == 8'h24 &&
    !running |=> $stable(signature_register))
    else $error("signature written by host");
  coding_hold_a: assert property (wr_en_in && addr_in == 8'h14 &&
    wr_data_in[1:0] == 2'b11 |=> $stable(coding_eff))
    else $error("reserved coding took effect");
  oe_bit_a: assert property (!sys_rst_in &&
    (!HAS_EXT_OE || ext_pin_alt_in) |=>
    data_oe_out == !$past(output_format_control[4]))
    else $error("output enable not from register bit");
endmodule

`default_nettype wire

/* File: verification/cst_host_model.sv */
/*
 * cst_host_model: host serial controller seen as byte register cycles.
 * assumes: one-cycle write and read strobes, read answer one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module cst_host_model (
  input wire logic clk_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wr_data_out,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in
);
  // ==========================================================
  // bus cycles, released lines show the inverse of the last value
  initial
  begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wr_data_out = 8'h00;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wr_data_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_en_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rd_valid_in ? rd_data_in : 8'hxx; // answer one cycle after strobe
  endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
/*
 * tb: self-checking bench for cst_config with the host model.
 * assumes: encode ticks every second clock, sample fixed at 16'h1234.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in, sys_rst_in, tick, ext_oe_n, ext_alt, l1;
  logic wr_en, rd_en, rd_valid, oe, lane, busy;
  logic [7:0] addr, wdata, rdata, r;
  logic [15:0] sample, dout, s1, s;
  logic disc, cm, se, strobe, sclk;
  logic [1:0] lt;
  logic [3:0] bw, term, drv;
  int fails = 0;
  int cmp_count = 0;
  int cnt;
  int cyc = 0;
  int c1;
  logic [39:0] rows [18] = '{
    40'h0f_fb_f3_1234, 40'h0f_04_04_8000, 40'h0f_00_00_1234,
    40'h10_01_01_1235, 40'h10_ff_ff_1233, 40'h10_00_00_1234,
    40'h11_00_00_1234, 40'h14_01_01_9234, 40'h14_02_02_1b2e,
    40'h14_03_03_1b2e, 40'h14_04_04_edcb, 40'h14_00_00_1234,
    40'h16_ff_8f_1234, 40'h16_00_00_1234, 40'h24_ff_00_1234,
    40'h25_ff_00_1234, 40'h40_ff_00_1234, 40'h15_a5_a5_1234};
  // ==========================================================
  // clock, ticks and tick count inside the window
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) tick <= sys_rst_in ? 1'b0 : ~tick;
  always @(posedge clk_in)
    cnt <= !busy ? 0 : cnt + int'(tick);
  // free cycle count, used to measure strobe phase offsets
  always @(posedge clk_in) cyc <= cyc + 1;
  cst_host_model u_cst_host_model (.clk_in(clk_in), .wr_en_out(wr_en),
    .rd_en_out(rd_en), .addr_out(addr), .wr_data_out(wdata),
    .rd_data_in(rdata), .rd_valid_in(rd_valid));
  cst_config u_cst_config (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr),
    .wr_data_in(wdata), .rd_data_out(rdata), .rd_valid_out(rd_valid),
    .encode_tick_in(tick), .sample_in(sample), .ext_oe_n_in(ext_oe_n),
    .ext_pin_alt_in(ext_alt), .data_out(dout), .data_oe_out(oe),
    .lane_sel_out(lane), .self_test_busy_out(busy),
    .analog_disconnect_out(disc), .lpf_bw_out(bw), .common_mode_en_out(cm),
    .single_ended_out(se), .logic_type_out(lt), .term_sel_out(term),
    .drive_sel_out(drv), .latch_strobe_out(strobe), .serial_clk_out(sclk));
  // ==========================================================
  // compare, verdict and self-test helpers
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one window over the bare stimulus in offset binary, no trims
  function automatic logic [15:0] ref_sig();
    logic [15:0] p;
    logic [15:0] acc;
    p = cst_pkg::PRBS_SEED;
    acc = 16'h0000;
    for (int k = 0; k < 256; k++)
    begin
      acc = acc + (p ^ 16'h8000);
      p = p[0] ? ((p >> 1) ^ cst_pkg::PRBS_TAPS) : (p >> 1);
    end
    return acc;
  endfunction
  task automatic run_st(input logic [7:0] ctl, output logic [15:0] sg);
    u_cst_host_model.write_reg(8'h0e, ctl);
    #1;
    chk("busy", 16'h1, {15'h0, busy});
    for (int i = 0; i < 1000 && busy !== 1'b0; i++)
    begin
      @(posedge clk_in);
      #1;
    end
    chk("ticks", 16'd256, cnt[15:0]);
    u_cst_host_model.read_reg(8'h24, sg[7:0]);
    u_cst_host_model.read_reg(8'h25, sg[15:8]);
  endtask
  initial
  begin
    #200us;
    fails++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    sys_rst_in = 1'b1;
    ext_oe_n = 1'b0;
    ext_alt = 1'b0;
    sample = 16'h1234;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    foreach (rows[i])
    begin
      u_cst_host_model.read_reg(rows[i][39:32], r);
      chk("reset value", 16'h0, {8'h0, r});
    end
    foreach (rows[i])
    begin
      u_cst_host_model.write_reg(rows[i][39:32], rows[i][31:24]);
      repeat (4) @(posedge clk_in);
      u_cst_host_model.read_reg(rows[i][39:32], r);
      chk("readback", {8'h0, rows[i][23:16]}, {8'h0, r});
      chk("data", rows[i][15:0], dout);
    end
    // double data rate: low half at the tick, high half next cycle
    u_cst_host_model.write_reg(8'h14, 8'h08);
    @(posedge clk_in iff tick == 1'b1);
    #1;
    chk("ddr low", 16'h0034, dout);
    @(posedge clk_in);
    #1;
    chk("ddr high", 16'h0012, dout);
    // analog, level and drive fields reach their pins
    u_cst_host_model.write_reg(8'h0f, 8'ha7);
    u_cst_host_model.write_reg(8'h14, 8'hc0);
    u_cst_host_model.write_reg(8'h15, 8'h3c);
    #1;
    chk("analog pins", 16'h00a7, {8'h0, bw, 1'b0, disc, cm, se});
    chk("disconnect", 16'h1, {15'h0, disc});
    chk("logic type", 16'h0003, {14'h0, lt});
    chk("drive pins", 16'h003c, {8'h0, term, drv});
    // phase select moves the strobe; invert flips the serial clock
    u_cst_host_model.write_reg(8'h16, 8'h03);
    @(posedge clk_in);
    @(negedge clk_in iff strobe == 1'b1);
    c1 = cyc;
    chk("sclk at strobe", 16'h1, {15'h0, sclk});
    u_cst_host_model.write_reg(8'h16, 8'h85);
    @(posedge clk_in);
    @(negedge clk_in iff strobe == 1'b1);
    chk("strobe phase", 16'h2, 16'((cyc - c1) % 16));
    chk("sclk inverted", 16'h0, {15'h0, sclk});
    // output enable: pin rules unless reassigned
    u_cst_host_model.write_reg(8'h14, 8'h10);
    repeat (2) @(posedge clk_in);
    #1;
    chk("oe pin", 16'h1, {15'h0, oe});
    ext_alt <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk("oe bit", 16'h0, {15'h0, oe});
    u_cst_host_model.write_reg(8'h14, 8'h20);
    repeat (2) @(posedge clk_in);
    #1;
    chk("oe on", 16'h1, {15'h0, oe});
    l1 = lane;
    repeat (2) @(posedge clk_in);
    #1;
    chk("lane", {15'h0, ~l1}, {15'h0, lane});
    u_cst_host_model.write_reg(8'h14, 8'h00);
    // self-test: clear, repeat, accumulate, reformat
    run_st(8'h05, s1);
    chk("first sig", ref_sig(), s1);
    u_cst_host_model.read_reg(8'h0e, r);
    chk("mode cleared", 16'h4, {8'h0, r});
    run_st(8'h05, s);
    chk("repeat sig", s1, s);
    run_st(8'h01, s);
    chk("cascade sig", s1 + s1, s);
    u_cst_host_model.read_reg(8'h0e, r);
    chk("mode kept", 16'h1, {8'h0, r});
    u_cst_host_model.write_reg(8'h24, 8'h00);
    u_cst_host_model.read_reg(8'h24, r);
    chk("sig ro", {8'h0, s[7:0]}, {8'h0, r});
    u_cst_host_model.write_reg(8'h14, 8'h04);
    run_st(8'h05, s);
    chk("invert sig", 16'h0 - s1 - 16'd256, s);
    // second reset in mid-window
    u_cst_host_model.write_reg(8'h0e, 8'h05);
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1;
    chk("busy reset", 16'h0, {15'h0, busy});
    u_cst_host_model.read_reg(8'h25, r);
    chk("sig reset", 16'h0, {8'h0, r});
    test_done();
  end
endmodule
`default_nettype wire
